/* File: hdl/asfp_defs.svh */
`ifndef ASFP_DEFS_SVH
`define ASFP_DEFS_SVH

// ---------------------------------------------------------------
// port geometry
// ---------------------------------------------------------------
`define ASFP_DATA_W 8
`define ASFP_SEL_W 2
`define ASFP_NUM_FIFOS 4
`define ASFP_DEPTH 16
`define ASFP_PTR_W 4
`define ASFP_CNT_W 5
`define ASFP_FULL_CNT 5'h10

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ASFP_DATA_RST 8'h00
`define ASFP_FLAG_RST 1'b0

`endif

/* File: hdl/asfp_pkg.sv */
package asfp_pkg;
    typedef logic [7:0] asfp_byte_t;
    typedef logic [1:0] asfp_sel_t;
    // strobe edge decoder states
    typedef enum logic [1:0] {
        ASFP_IDLE = 2'b00,
        ASFP_RD_ACTIVE = 2'b01,
        ASFP_WR_ACTIVE = 2'b10,
        ASFP_PKT_ACTIVE = 2'b11
    } asfp_state_t;
endpackage

/* File: hdl/asfp_sync.sv */
`timescale 1ns/1ps
`include "asfp_defs.svh"
module asfp_sync
    import asfp_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // reset to all ones: strobes are idle high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: hdl/asfp_port.sv */
`timescale 1ns/1ps
`include "asfp_defs.svh"
// Behaviour
// - output enable alone shows leftover word
// - read needs chip select and read strobe
// - read strobe shows current fifo word
// - burst read presents word, then advances pointer
// - write release captures data, post-increments pointer
// - flags update after each write release
// - packet commit releases short packet
module asfp_port
    import asfp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // master strobes, active low, and fifo select, all asynchronous
    input wire logic port_chip_select_n,
    input wire logic bus_output_enable_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic packet_commit_strobe_n,
    input wire logic [1:0] fifo_select,
    // data bus as three signals
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // flags for the selected fifo
    output logic fifo_empty,
    output logic fifo_full,
    // committed packet towards usb side
    output logic commit_pulse,
    output logic [1:0] commit_fifo,
    output logic [4:0] commit_count
);
    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic [14:0] raw_in;
    logic [14:0] syn;
    logic cs_n_s, oe_n_s, rd_n_s, wr_n_s, pk_n_s;
    logic [1:0] sel_s;
    logic [7:0] din_s;

    assign raw_in = {port_chip_select_n, bus_output_enable_n, read_strobe_n, write_strobe_n,
                     packet_commit_strobe_n, fifo_select, data_in};
    // every pin passes two flops before use
    asfp_sync #(.W(15)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in(raw_in),
        .sync_out(syn)
    );
    assign {cs_n_s, oe_n_s, rd_n_s, wr_n_s, pk_n_s, sel_s, din_s} = syn;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] mem_q [0:63];
    logic [7:0] mem_d [0:63];
    logic [3:0] rptr_q [0:3];
    logic [3:0] rptr_d [0:3];
    logic [3:0] wptr_q [0:3];
    logic [3:0] wptr_d [0:3];
    logic [4:0] cnt_q [0:3];
    logic [4:0] cnt_d [0:3];
    logic [4:0] pend_q [0:3];
    logic [4:0] pend_d [0:3];
    asfp_state_t state_q, state_d;
    logic [1:0] sel_q, sel_d;
    logic [7:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic empty_q, empty_d, full_q, full_d;
    logic cpulse_q, cpulse_d;
    logic [1:0] cfifo_q, cfifo_d;
    logic [4:0] ccount_q, ccount_d;

    // flat memory index from fifo and pointer
    function automatic logic [5:0] mem_idx(input logic [1:0] f, input logic [3:0] p);
        mem_idx = {f, p};
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        mem_d = mem_q;
        rptr_d = rptr_q;
        wptr_d = wptr_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        state_d = state_q;
        sel_d = sel_q;
        dout_d = dout_q;
        cpulse_d = 1'b0;
        cfifo_d = cfifo_q;
        ccount_d = ccount_q;
        // bus driven whenever output enable is low
        oe_d = !oe_n_s;
        case (state_q)
            ASFP_IDLE: begin
                sel_d = sel_s;
                if (!cs_n_s && !rd_n_s) begin
                    state_d = ASFP_RD_ACTIVE;
                    // present current word; leftover dout_q shown until now
                    if (cnt_q[sel_s] != 5'h00) begin
                        dout_d = mem_q[mem_idx(sel_s, rptr_q[sel_s])];
                    end
                end else if (!cs_n_s && !wr_n_s) begin
                    state_d = ASFP_WR_ACTIVE;
                end else if (!cs_n_s && !pk_n_s) begin
                    state_d = ASFP_PKT_ACTIVE;
                end
            end
            ASFP_RD_ACTIVE: begin
                if (rd_n_s || cs_n_s) begin
                    state_d = ASFP_IDLE;
                    // pointer advances only after the word was shown
                    if (cnt_q[sel_q] != 5'h00) begin
                        rptr_d[sel_q] = rptr_q[sel_q] + 4'h1;
                        cnt_d[sel_q] = cnt_q[sel_q] - 5'h01;
                    end
                end
            end
            ASFP_WR_ACTIVE: begin
                if (wr_n_s) begin
                    state_d = ASFP_IDLE;
                    // write on release edge, full fifo drops the byte
                    if (cnt_q[sel_q] != `ASFP_FULL_CNT) begin
                        mem_d[mem_idx(sel_q, wptr_q[sel_q])] = din_s;
                        wptr_d[sel_q] = wptr_q[sel_q] + 4'h1;
                        cnt_d[sel_q] = cnt_q[sel_q] + 5'h01;
                        pend_d[sel_q] = pend_q[sel_q] + 5'h01;
                    end
                end
            end
            ASFP_PKT_ACTIVE: begin
                if (pk_n_s) begin
                    state_d = ASFP_IDLE;
                    // short packets commit too, even empty ones
                    cpulse_d = 1'b1;
                    cfifo_d = sel_q;
                    ccount_d = pend_q[sel_q];
                    pend_d[sel_q] = 5'h00;
                end
            end
            default: state_d = ASFP_IDLE;
        endcase
        // flags follow the selected fifo's new fill level
        empty_d = (cnt_d[sel_s] == 5'h00);
        full_d = (cnt_d[sel_s] == `ASFP_FULL_CNT);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= `ASFP_DATA_RST;
            end
            for (int f = 0; f < 4; f++) begin
                rptr_q[f] <= 4'h0;
                wptr_q[f] <= 4'h0;
                cnt_q[f] <= 5'h00;
                pend_q[f] <= 5'h00;
            end
            state_q <= ASFP_IDLE;
            sel_q <= 2'h0;
            dout_q <= `ASFP_DATA_RST;
            oe_q <= 1'b0;
            empty_q <= 1'b1;
            full_q <= `ASFP_FLAG_RST;
            cpulse_q <= 1'b0;
            cfifo_q <= 2'h0;
            ccount_q <= 5'h00;
        end else begin
            mem_q <= mem_d;
            rptr_q <= rptr_d;
            wptr_q <= wptr_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            state_q <= state_d;
            sel_q <= sel_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            empty_q <= empty_d;
            full_q <= full_d;
            cpulse_q <= cpulse_d;
            cfifo_q <= cfifo_d;
            ccount_q <= ccount_d;
        end
    end

    // outputs straight from flops
    assign data_out = dout_q;
    assign data_oe = oe_q;
    assign fifo_empty = empty_q;
    assign fifo_full = full_q;
    assign commit_pulse = cpulse_q;
    assign commit_fifo = cfifo_q;
    assign commit_count = ccount_q;
endmodule

/* File: test/asfp_port_checker.sv */
`timescale 1ns/1ps
module asfp_port_checker
    import asfp_pkg::*;
(
    // clock, reset and master pins
    input wire logic clock,
    input wire logic resetn,
    input wire logic port_chip_select_n,
    input wire logic bus_output_enable_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic packet_commit_strobe_n,
    input wire logic [1:0] fifo_select,
    // device outputs
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic fifo_empty,
    input wire logic fifo_full,
    input wire logic commit_pulse,
    input wire logic [1:0] commit_fifo,
    input wire logic [4:0] commit_count
);
    // ---------------------------------------------------------------
    // port relations, all in the interface clock domain
    // ---------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_oe_follows_pin: assert property (data_oe == !$past(bus_output_enable_n, 3))
        else $error("bus drive does not follow enable");
    a_word_needs_read: assert property ($changed(data_out) |-> !$past(read_strobe_n, 2))
        else $error("data word changed without read");
    a_read_needs_cs: assert property ($changed(data_out) |-> !$past(port_chip_select_n, 2))
        else $error("data word changed without select");
    a_pulse_once: assert property (commit_pulse |=> !commit_pulse)
        else $error("commit pulse too long");
    a_pulse_cause: assert property (commit_pulse |-> $past(packet_commit_strobe_n, 2)
        && !$past(packet_commit_strobe_n, 5))
        else $error("commit pulse without strobe release");
    a_commit_holds: assert property (!commit_pulse |-> $stable(commit_count) && $stable(commit_fifo))
        else $error("commit fields moved without pulse");
    a_commit_fifo: assert property (commit_pulse |-> commit_fifo == $past(fifo_select, 4))
        else $error("commit names wrong fifo");
    a_count_bound: assert property (commit_pulse |-> commit_count <= 5'h10)
        else $error("commit count beyond depth");
    a_flags_apart: assert property (!(fifo_empty && fifo_full))
        else $error("empty and full together");
    // a fifo only fills through a write release or a change of select
    a_empty_fall_cause: assert property ($fell(fifo_empty) |->
        ($past(write_strobe_n, 3) && !$past(write_strobe_n, 4))
        || ($past(fifo_select, 3) != $past(fifo_select, 4)))
        else $error("empty cleared without write release");
    a_full_rise_cause: assert property ($rose(fifo_full) |->
        ($past(write_strobe_n, 3) && !$past(write_strobe_n, 4))
        || ($past(fifo_select, 3) != $past(fifo_select, 4)))
        else $error("full set without write release");
endmodule
bind asfp_port asfp_port_checker u_chk (.clock, .resetn, .port_chip_select_n, .bus_output_enable_n,
    .read_strobe_n, .write_strobe_n, .packet_commit_strobe_n, .fifo_select, .data_out, .data_oe, .fifo_empty,
    .fifo_full, .commit_pulse, .commit_fifo, .commit_count);

/* File: test/asfp_master.sv */
`timescale 1ns/1ps
module asfp_master (
    // interface clock
    input wire logic clock,
    // strobes, select and bus towards the port
    output logic port_chip_select_n,
    output logic bus_output_enable_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic packet_commit_strobe_n,
    output logic [1:0] fifo_select,
    output logic [7:0] data_in
);
    // chip select tied low by default, strobes idle high
    initial {port_chip_select_n, bus_output_enable_n, read_strobe_n, write_strobe_n,
        packet_commit_strobe_n, fifo_select, data_in} = 15'h3c00;

    // one strobe, k 0 read, 1 write, 2 commit; never two at once
    task automatic strobe(input int k, input logic [1:0] s, input logic [7:0] d);
        @(negedge clock);
        fifo_select = s;
        data_in = d;
        repeat (2) @(negedge clock);
        read_strobe_n = (k != 0);
        write_strobe_n = (k != 1);
        packet_commit_strobe_n = (k != 2);
        repeat (4) @(negedge clock);
        {read_strobe_n, write_strobe_n, packet_commit_strobe_n} = 3'h7;
        // select and data held past release, then the bus is scrambled
        repeat (4) @(negedge clock);
        data_in = ~d;
    endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic port_chip_select_n, bus_output_enable_n, read_strobe_n, write_strobe_n, packet_commit_strobe_n;
    logic [1:0] fifo_select, commit_fifo, got_fifo;
    logic [7:0] data_in, data_out;
    logic data_oe, fifo_empty, fifo_full, commit_pulse;
    logic [4:0] commit_count, got_cnt;
    int got_n = 0;
    int mismatches = 0;
    int n_checks = 0;

    asfp_port u_dut (.clock, .resetn, .port_chip_select_n, .bus_output_enable_n, .read_strobe_n,
        .write_strobe_n, .packet_commit_strobe_n, .fifo_select, .data_in, .data_out, .data_oe,
        .fifo_empty, .fifo_full, .commit_pulse, .commit_fifo, .commit_count);
    asfp_master u_m (.clock, .port_chip_select_n, .bus_output_enable_n, .read_strobe_n,
        .write_strobe_n, .packet_commit_strobe_n, .fifo_select, .data_in);

    // ---------------------------------------------------------------
    // clock, commit capture and checking helpers
    // ---------------------------------------------------------------
    initial begin
        forever #2.5 clock = ~clock;
    end

    // one-cycle pulse, so latch its fields as it passes
    always @(posedge clock) begin
        if (commit_pulse === 1'b1) begin
            got_n <= got_n + 1;
            got_cnt <= commit_count;
            got_fifo <= commit_fifo;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // enable alone shows the word left from reset
    task automatic t_oe();
        u_m.bus_output_enable_n = 1'b0; // kept low for every read
        repeat (5) @(negedge clock);
        chk(8'(data_oe), 8'h01);
        chk(data_out, 8'h00);
        $display("t_oe done");
    endtask

    // burst write, burst read, then a read of the drained fifo
    task automatic t_burst();
        for (int i = 0; i < 3; i++) u_m.strobe(1, 2'h1, 8'ha0 + 8'(i));
        chk(8'(fifo_empty), 8'h00);
        for (int i = 0; i < 3; i++) begin
            u_m.strobe(0, 2'h1, 8'h00);
            chk(data_out, 8'ha0 + 8'(i));
        end
        chk(8'(fifo_empty), 8'h01);
        u_m.strobe(0, 2'h1, 8'h00);
        chk(data_out, 8'ha2);
        $display("t_burst done");
    endtask

    // seventeen writes, the last one dropped; other fifo untouched
    task automatic t_full();
        for (int i = 0; i < 17; i++) u_m.strobe(1, 2'h0, 8'h10 + 8'(i));
        chk(8'(fifo_full), 8'h01);
        u_m.strobe(0, 2'h0, 8'h00);
        chk(data_out, 8'h10);
        chk(8'(fifo_full), 8'h00);
        // drain the rest; the dropped byte must never show up
        for (int i = 1; i < 16; i++) begin
            u_m.strobe(0, 2'h0, 8'h00);
            chk(data_out, 8'h10 + 8'(i));
        end
        u_m.strobe(0, 2'h0, 8'h00);
        chk(data_out, 8'h1f);
        u_m.fifo_select = 2'h3;
        repeat (4) @(negedge clock);
        chk(8'(fifo_empty), 8'h01);
        $display("t_full done");
    endtask

    // short and empty packet commits, then strobes with the port deselected
    task automatic t_commit();
        u_m.strobe(1, 2'h2, 8'h55);
        u_m.strobe(1, 2'h2, 8'h66);
        u_m.strobe(2, 2'h2, 8'h00);
        chk(8'(got_n), 8'h01);
        chk(8'(got_cnt), 8'h02);
        chk(8'(got_fifo), 8'h02);
        u_m.strobe(2, 2'h2, 8'h00);
        chk(8'(got_cnt), 8'h00);
        u_m.port_chip_select_n = 1'b1;
        u_m.strobe(1, 2'h3, 8'h77);
        u_m.strobe(2, 2'h3, 8'h00);
        chk(8'(got_n), 8'h02);
        u_m.port_chip_select_n = 1'b0;
        u_m.bus_output_enable_n = 1'b1;
        repeat (4) @(negedge clock);
        chk(8'(fifo_empty), 8'h01);
        chk(8'(data_oe), 8'h00);
        $display("t_commit done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // reset for sixteen cycles, then the scenarios in turn
    initial begin
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        t_oe();
        t_burst();
        t_full();
        t_commit();
        test_done();
    end
endmodule
